// >>> rtl/fcl_link_top.sv
// Follower charger current link: registers, events and two pulse links
// Overview of operation
// [RL1] First follower thermal change sets flag bit 0
// [RL2] Mask bit 4 gates second follower fault
// [RL3] Mask bit 3 gates first follower fault
// [RL4] Mask bit 2 gates voltage phase event
// [RL5] Mask bits 1, 0 gate thermal events
// [RL6] Follower one gets min of master, own code
// [RL7] Follower one bypass sends own code unchanged
// [RL8] Follower two gets min of master, own code
// [RL9] Follower two bypass sends own code unchanged
// [RL10] Code is sent as that many pulses
// [RL11] Follower treats codes zero to two as off
// [RL12] Follower maps codes to 50 mA steps
// [RL13] Read-only readback of follower one sent code
// [RL14] Follower two code held in bits 5:0
// [RL15] Fault flags bits 4, 3, cleared on read
// [RL16] Voltage phase flag only while gauge bit low
// [RL17] Read-only readback of follower two sent code
// [RL18] Interrupt while unmasked flag set
// [RL19] New burst on code change, after current one
//
// Implementation choice: the plain strobed port.
module fcl_link_top
	import fcl_pkg::*;
(
	input  wire logic              mclk,                    // 50 MHz clock
	input  wire logic              rst,                     // Async reset
	input  wire logic [7:0]        reg_addr,                // Register address
	input  wire logic [7:0]        reg_wdata,               // Write data
	input  wire logic              reg_wr,                  // Write strobe
	input  wire logic              reg_rd,                  // Read strobe
	output      logic [7:0]        reg_rdata,               // Read data, +1
	input  wire logic [CODE_W-1:0] master_cc_code,          // Master CC code
	input  wire logic              gauge_select_bit,        // Gauge select
	input  wire logic              voltage_phase_state,     // Master in CV
	input  wire logic              first_follower_thermal_state,  // Pin
	input  wire logic              second_follower_thermal_state, // Pin
	input  wire logic              first_follower_fault,    // Fault pin
	input  wire logic              second_follower_fault,   // Fault pin
	output      logic              first_follower_pulse,    // Link one
	output      logic              second_follower_pulse,   // Link two
	output      logic              irq                      // Level, high
);

	// Event sources gathered in flag bit order
	logic [NUM_EVENTS-1:0] async_in;
	logic [NUM_EVENTS-1:0] sync_a_r;
	logic [NUM_EVENTS-1:0] sync_b_r;
	logic [NUM_EVENTS-1:0] prev_r;
	logic [NUM_EVENTS-1:0] rise;
	logic [NUM_EVENTS-1:0] toggle;
	logic [NUM_EVENTS-1:0] events;

	// Register file
	logic [7:0]        flags_r;
	logic [7:0]        flags_nxt;
	logic [7:0]        mask_r;
	logic [7:0]        one_cfg_r;
	logic [7:0]        two_cfg_r;
	logic [CODE_W-1:0] one_readback_r;
	logic [CODE_W-1:0] two_readback_r;
	logic [7:0]        rdata_r;
	logic [7:0]        rdata_nxt;
	logic              irq_r;
	logic              pulse_one_r;
	logic              pulse_two_r;

	// Decode
	logic hit_flags;
	logic hit_mask;
	logic hit_one_cfg;
	logic hit_two_cfg;
	logic rd_flags;

	// Per follower view of its configuration
	logic [7:0]        cfg_of   [NUM_FOLLOWERS];
	logic [CODE_W-1:0] final_of [NUM_FOLLOWERS];
	logic [CODE_W-1:0] sent_of  [NUM_FOLLOWERS];
	logic              pin_of   [NUM_FOLLOWERS];

	fcl_link_if lnk [NUM_FOLLOWERS] ();

	assign async_in[EV_ONE_THERMAL] = first_follower_thermal_state;
	assign async_in[EV_TWO_THERMAL] = second_follower_thermal_state;
	assign async_in[EV_VOLT_PHASE]  = voltage_phase_state;
	assign async_in[EV_ONE_FAULT]   = first_follower_fault;
	assign async_in[EV_TWO_FAULT]   = second_follower_fault;

	// Two-flop synchronisers, one per event pin
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_sync
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					sync_a_r[gi] <= 1'b0;
					sync_b_r[gi] <= 1'b0;
				end else begin
					sync_a_r[gi] <= async_in[gi];
					sync_b_r[gi] <= sync_a_r[gi];
				end
			end
		end
	endgenerate

	// Previous synced level, for edge detection past the synchroniser
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prev_r <= '0;
		end else begin
			prev_r <= sync_b_r;
		end
	end

	assign rise   = sync_b_r & ~prev_r;
	assign toggle = sync_b_r ^ prev_r;

	// Event pulses: thermal on any change, fault and CV on entry
	always_comb begin
		events = '0;
		events[EV_ONE_THERMAL] = toggle[EV_ONE_THERMAL]; // RL1
		events[EV_TWO_THERMAL] = toggle[EV_TWO_THERMAL];
		// Gauge owns the CV event while its select bit is high
		events[EV_VOLT_PHASE] = rise[EV_VOLT_PHASE] &
			~gauge_select_bit; // RL16
		events[EV_ONE_FAULT] = rise[EV_ONE_FAULT]; // RL15
		events[EV_TWO_FAULT] = rise[EV_TWO_FAULT]; // RL15
	end

	// Address decode
	assign hit_flags   = (reg_addr == ADDR_EVENT_FLAGS);
	assign hit_mask    = (reg_addr == ADDR_EVENT_MASK);
	assign hit_one_cfg = (reg_addr == ADDR_ONE_CFG);
	assign hit_two_cfg = (reg_addr == ADDR_TWO_CFG);
	assign rd_flags    = reg_rd && hit_flags;

	// Flags clear on read; an event in the read cycle survives it
	always_comb begin
		flags_nxt = flags_r;
		if (rd_flags) begin
			flags_nxt = EVENT_FLAGS_RST;
		end
		flags_nxt[NUM_EVENTS-1:0] = flags_nxt[NUM_EVENTS-1:0] | events;
	end

	// Sticky event flags, upper bits stay zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flags_r <= EVENT_FLAGS_RST;
		end else begin
			flags_r <= flags_nxt; // RL1
		end
	end

	// Mask register, everything masked out of reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mask_r <= EVENT_MASK_RST;
		end else if (reg_wr && hit_mask) begin
			mask_r <= reg_wdata;
		end
	end

	// Follower one configuration; reserved bit 6 is not stored
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			one_cfg_r <= CFG_RST;
		end else if (reg_wr && hit_one_cfg) begin
			one_cfg_r <= reg_wdata & CFG_WR_MASK;
		end
	end

	// Follower two configuration, same layout as follower one
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			two_cfg_r <= CFG_RST;
		end else if (reg_wr && hit_two_cfg) begin
			two_cfg_r <= reg_wdata & CFG_WR_MASK; // RL14
		end
	end

	assign cfg_of[0] = one_cfg_r;
	assign cfg_of[1] = two_cfg_r;

	// Final code per follower and its transmitter
	generate
		for (gi = 0; gi < NUM_FOLLOWERS; gi++) begin : g_follower
			logic [CODE_W-1:0] own;
			logic              bypass;

			assign own    = cfg_of[gi][CODE_W-1:0];
			assign bypass = cfg_of[gi][CFG_BYPASS_BIT];
			// Min selector keeps a follower at or below the master
			assign final_of[gi] = bypass ? own : // RL7 RL9
				((master_cc_code < own) ? master_cc_code : own); // RL6 RL8

			assign lnk[gi].req_code = final_of[gi];
			assign sent_of[gi]      = lnk[gi].sent_code;
			assign pin_of[gi]       = lnk[gi].pin;

			fcl_pulse_tx u_tx (
				.mclk (mclk),
				.rst  (rst),
				.lk   (lnk[gi])
			);
		end
	endgenerate

	// Readback of the codes actually put on each link
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			one_readback_r <= CODE_RST;
			two_readback_r <= CODE_RST;
		end else begin
			one_readback_r <= sent_of[0]; // RL13
			two_readback_r <= sent_of[1]; // RL17
		end
	end

	// Pulse lines re-registered so top outputs come from flops here
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pulse_one_r <= 1'b0;
			pulse_two_r <= 1'b0;
		end else begin
			pulse_one_r <= pin_of[0]; // RL10
			pulse_two_r <= pin_of[1]; // RL10
		end
	end

	// Read mux; unmapped addresses and reserved bits read zero, except mask bits 7:5, which read back as written
	always_comb begin
		rdata_nxt = 8'h00;
		unique case (reg_addr)
			ADDR_EVENT_FLAGS:  rdata_nxt = flags_r;
			ADDR_EVENT_MASK:   rdata_nxt = mask_r;
			ADDR_ONE_CFG:      rdata_nxt = one_cfg_r;
			ADDR_TWO_CFG:      rdata_nxt = two_cfg_r;
			ADDR_ONE_READBACK: rdata_nxt = {2'b00, one_readback_r}; // RL13
			ADDR_TWO_READBACK: rdata_nxt = {2'b00, two_readback_r}; // RL17
			default:           rdata_nxt = 8'h00;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 8'h00;
		end
	end

	// Interrupt follows the next flag value, so a read drops it at once
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= // RL18
				(flags_nxt[EV_TWO_FAULT]   & ~mask_r[EV_TWO_FAULT])   | // RL2
				(flags_nxt[EV_ONE_FAULT]   & ~mask_r[EV_ONE_FAULT])   | // RL3
				(flags_nxt[EV_VOLT_PHASE]  & ~mask_r[EV_VOLT_PHASE])  | // RL4
				(flags_nxt[EV_TWO_THERMAL] & ~mask_r[EV_TWO_THERMAL]) | // RL5
				(flags_nxt[EV_ONE_THERMAL] & ~mask_r[EV_ONE_THERMAL]);  // RL5
		end
	end

	assign reg_rdata             = rdata_r;
	assign irq                   = irq_r;
	assign first_follower_pulse  = pulse_one_r;
	assign second_follower_pulse = pulse_two_r;

endmodule

// >>> rtl/fcl_pkg.sv
// Constants and types shared by the follower current link design
package fcl_pkg;

	// Clock and link timing
	localparam int unsigned CLK_PERIOD_NS  = 20;
	localparam int unsigned PULSE_HIGH_NS  = 10_000;
	localparam int unsigned PULSE_LOW_NS   = 10_000;
	localparam int unsigned BURST_GAP_NS   = 50_000;
	localparam int unsigned TMR_W          = 16;
	// Least times, rounded up to whole cycles
	localparam logic [TMR_W-1:0] PULSE_HIGH_CYC =
		TMR_W'((PULSE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] PULSE_LOW_CYC =
		TMR_W'((PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] BURST_GAP_CYC =
		TMR_W'((BURST_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Geometry
	localparam int unsigned CODE_W        = 6;
	localparam int unsigned NUM_FOLLOWERS = 2;
	localparam int unsigned NUM_EVENTS    = 5;

	// Register offsets
	localparam logic [7:0] ADDR_EVENT_FLAGS  = 8'h80;
	localparam logic [7:0] ADDR_EVENT_MASK   = 8'h81;
	localparam logic [7:0] ADDR_ONE_CFG      = 8'h82;
	localparam logic [7:0] ADDR_TWO_CFG      = 8'h83;
	localparam logic [7:0] ADDR_ONE_READBACK = 8'h84;
	localparam logic [7:0] ADDR_TWO_READBACK = 8'h85;

	// Reset values
	localparam logic [7:0] EVENT_FLAGS_RST = 8'h00;
	localparam logic [7:0] EVENT_MASK_RST  = 8'hff;
	localparam logic [7:0] CFG_RST         = 8'h00;
	localparam logic [CODE_W-1:0] CODE_RST = 6'h00;

	// Field positions and masks
	localparam int unsigned EV_ONE_THERMAL = 0;
	localparam int unsigned EV_TWO_THERMAL = 1;
	localparam int unsigned EV_VOLT_PHASE  = 2;
	localparam int unsigned EV_ONE_FAULT   = 3;
	localparam int unsigned EV_TWO_FAULT   = 4;
	localparam int unsigned CFG_BYPASS_BIT = 7;
	localparam logic [7:0]  CFG_WR_MASK    = 8'hbf;

	// Pulse transmitter states
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_HIGH = 4'b0010,
		TX_LOW  = 4'b0100,
		TX_GAP  = 4'b1000
	} fcl_tx_state_t;

endpackage

// >>> rtl/fcl_link_if.sv
// Carrier between the register core and one pulse transmitter
interface fcl_link_if;
	import fcl_pkg::*;
	logic [CODE_W-1:0] req_code;  // Final code wanted on the link
	logic [CODE_W-1:0] sent_code; // Code of the burst last started
	logic              busy;      // Burst or closing gap in progress
	logic              pin;       // Registered pulse line

	modport ctrl (output req_code, input sent_code, input busy, input pin);
	modport tx   (input req_code, output sent_code, output busy, output pin);
endinterface

// >>> rtl/fcl_pulse_tx.sv
// Pulse-count transmitter for one follower link
module fcl_pulse_tx
	import fcl_pkg::*;
(
	input wire logic mclk, // 50 MHz clock
	input wire logic rst,  // Async reset, active high
	fcl_link_if.tx   lk    // Code in, pulse line out
);

	fcl_tx_state_t     state_r;
	logic [TMR_W-1:0]  tmr_r;
	logic [CODE_W-1:0] left_r;
	logic [CODE_W-1:0] sent_r;
	logic              pin_r;
	logic              tmr_done;
	logic              start;

	assign tmr_done = (tmr_r == TMR_W'(1));
	// New burst only from idle, so a running one always completes
	assign start = (state_r == TX_IDLE) && (lk.req_code != sent_r); // RL19

	// Sequencer: pin level, phase timer and phase state
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r <= TX_IDLE;
			tmr_r   <= '0;
			pin_r   <= 1'b0;
		end else begin
			unique case (state_r)
				TX_IDLE: begin
					if (start && lk.req_code == CODE_RST) begin
						// Zero code: gap alone, follower counts none
						state_r <= TX_GAP;
						tmr_r   <= BURST_GAP_CYC;
					end else if (start) begin
						state_r <= TX_HIGH;
						tmr_r   <= PULSE_HIGH_CYC;
						pin_r   <= 1'b1;
					end
				end
				TX_HIGH: begin
					if (tmr_done) begin
						pin_r <= 1'b0;
						if (left_r == CODE_W'(1)) begin
							state_r <= TX_GAP;
							tmr_r   <= BURST_GAP_CYC;
						end else begin
							state_r <= TX_LOW;
							tmr_r   <= PULSE_LOW_CYC;
						end
					end else begin
						tmr_r <= tmr_r - TMR_W'(1);
					end
				end
				TX_LOW: begin
					if (tmr_done) begin
						state_r <= TX_HIGH;
						tmr_r   <= PULSE_HIGH_CYC;
						pin_r   <= 1'b1;
					end else begin
						tmr_r <= tmr_r - TMR_W'(1);
					end
				end
				TX_GAP: begin
					if (tmr_done) begin
						state_r <= TX_IDLE;
					end else begin
						tmr_r <= tmr_r - TMR_W'(1);
					end
				end
			endcase
		end
	end

	// Burst bookkeeping: one pulse per code unit
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			left_r <= CODE_RST;
			sent_r <= CODE_RST;
		end else if (start) begin
			left_r <= lk.req_code; // RL10
			sent_r <= lk.req_code;
		end else if (state_r == TX_HIGH && tmr_done) begin
			left_r <= left_r - CODE_W'(1);
		end
	end

	assign lk.sent_code = sent_r;
	assign lk.busy      = (state_r != TX_IDLE);
	assign lk.pin       = pin_r;

endmodule

// >>> verification/fcl_link_assertions.sv
// Port-level assertions for the follower current link top
module fcl_link_assertions
	import fcl_pkg::*;
(
	input wire logic       mclk,                         // Clock
	input wire logic       rst,                          // Reset
	input wire logic [7:0] reg_addr,                     // Address
	input wire logic [7:0] reg_wdata,                    // Write data
	input wire logic       reg_wr,                       // Write strobe
	input wire logic       reg_rd,                       // Read strobe
	input wire logic [7:0] reg_rdata,                    // Read data
	input wire logic       gauge_select_bit,             // Gauge select
	input wire logic       voltage_phase_state,          // CV pin
	input wire logic       first_follower_thermal_state, // Thermal pin
	input wire logic       first_follower_fault,         // Fault pin
	input wire logic       second_follower_fault,        // Fault pin
	input wire logic       first_follower_pulse,         // Link one
	input wire logic       irq                           // Interrupt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mask_r;
	logic [15:0] hi_r;
	logic [15:0] lo_r;

	// Shadow mask, so event checks know what may reach irq
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			mask_r <= EVENT_MASK_RST;
		else if (reg_wr && reg_addr == ADDR_EVENT_MASK)
			mask_r <= reg_wdata;
	end
	// Run lengths of the link line; low count saturates
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hi_r <= '0;
			lo_r <= '1;
		end else if (first_follower_pulse) begin
			hi_r <= hi_r + 16'h0001;
			lo_r <= '0;
		end else begin
			hi_r <= '0;
			lo_r <= (lo_r == '1) ? lo_r : lo_r + 16'h0001;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_one_fault_irq: assert property (
		$rose(first_follower_fault) && !mask_r[3] |-> ##[1:4] irq)
		else $error("fault one did not raise irq");
	a_two_fault_irq: assert property (
		$rose(second_follower_fault) && !mask_r[4] |-> ##[1:4] irq)
		else $error("fault two did not raise irq");
	a_one_thermal_irq: assert property (
		$changed(first_follower_thermal_state) && !mask_r[0]
		|-> ##[1:4] irq) else $error("thermal change did not raise irq");
	a_volt_phase_irq: assert property (
		$rose(voltage_phase_state) && !gauge_select_bit && !mask_r[2]
		|-> ##[1:4] irq) else $error("voltage phase did not raise irq");
	a_all_masked_quiet: assert property (
		mask_r[4:0] == 5'h1f && $past(mask_r[4:0]) == 5'h1f |-> !irq)
		else $error("irq high with every event masked");
	a_pulse_high_len: assert property (
		$fell(first_follower_pulse) |-> hi_r == PULSE_HIGH_CYC)
		else $error("link pulse high time wrong");
	a_pulse_low_len: assert property (
		$rose(first_follower_pulse) |-> lo_r >= PULSE_LOW_CYC)
		else $error("link low time too short");
	a_rdata_idle_zero: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	a_readback_top_bits: assert property (
		$past(reg_rd && reg_addr == ADDR_ONE_READBACK)
		|-> reg_rdata[7:6] == 2'b00) else $error("readback bits 7:6 set");

	c_irq_seen: cover property (irq);
	c_pulse_done: cover property ($fell(first_follower_pulse));
	c_flag_read: cover property (reg_rd && reg_addr == ADDR_EVENT_FLAGS
		##1 !irq);
endmodule

bind fcl_link_top fcl_link_assertions i_chk (
	.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.gauge_select_bit, .voltage_phase_state, .first_follower_thermal_state,
	.first_follower_fault, .second_follower_fault, .first_follower_pulse,
	.irq);

// >>> verification/fcl_follower_model.sv
// Behavioural follower charger: decodes a burst of link pulses
module fcl_follower_model
	import fcl_pkg::*;
(
	input wire logic              mclk,   // Clock
	input wire logic              pulse,  // Link line from the master
	output     logic [CODE_W-1:0] code,   // Code of the last burst
	output     int                bursts, // Bursts decoded so far
	output     int                ma      // Charge current in mA
);
	timeunit 1ns;
	timeprecision 1ns;
	// Rest past a pulse gap but inside the burst gap ends a burst
	localparam int END_CYC = 3 * int'(PULSE_LOW_CYC);
	int   cnt = 0;
	int   low = 0;
	logic prev = 1'b0;

	initial begin
		code = '0;
		bursts = 0;
		ma = 0;
	end
	// Count rising edges, decode once the line rests
	always @(posedge mclk) begin
		low = pulse ? 0 : low + 1;
		if (pulse && !prev)
			cnt++;
		if (low == END_CYC && cnt != 0) begin
			code <= CODE_W'(cnt);
			ma <= cnt < 3 ? 0 : cnt >= 60 ? 3000 : 50 * cnt - 50;
			bursts <= bursts + 1;
			cnt = 0;
		end
		prev = pulse;
	end
endmodule

// >>> verification/fcl_link_top_bench.sv
// Self-checking bench for the follower current link top
module fcl_link_top_bench import fcl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic              mclk, rst, reg_wr, reg_rd, irq, gauge, vph, p1, p2;
	logic [7:0]        reg_addr, reg_wdata, reg_rdata, a;
	logic [CODE_W-1:0] mcc, c1, c2, code1, code2;
	logic [1:0]        th, flt;
	int                errors, checked, cyc, n1, n2, s1;

	fcl_link_top i_dut (
		.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.master_cc_code(mcc), .gauge_select_bit(gauge),
		.voltage_phase_state(vph), .first_follower_thermal_state(th[0]),
		.second_follower_thermal_state(th[1]),
		.first_follower_fault(flt[0]), .second_follower_fault(flt[1]),
		.first_follower_pulse(p1), .second_follower_pulse(p2), .irq);
	fcl_follower_model i_f1 (.mclk, .pulse(p1), .code(code1), .bursts(n1),
		.ma());
	fcl_follower_model i_f2 (.mclk, .pulse(p2), .code(code2), .bursts(n2),
		.ma());

	task automatic chk(input string nm, input logic [7:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] ad, dt);
		@(posedge mclk);
		reg_addr <= ad;
		reg_wdata <= dt;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// Data is taken 1 ns into the single cycle it stands
	task automatic rchk(input string nm, input logic [7:0] ad, exp);
		@(posedge mclk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(nm, reg_rdata, exp);
	endtask
	// Pins held 6 cycles so the synchronisers see them
	task automatic fire(input int i);
		@(posedge mclk);
		case (i)
		0: th[0] <= ~th[0];
		1: th[1] <= ~th[1];
		2: vph <= 1'b1;
		3: flt[0] <= 1'b1;
		default: flt[1] <= 1'b1;
		endcase
		repeat (6) @(posedge mclk);
		vph <= 1'b0;
		flt <= 2'b00;
		repeat (6) @(posedge mclk);
	endtask
	task automatic wait_b(input int w1, w2);
		for (int k = 0; k < 20000 && (n1 < w1 || n2 < w2); k++)
			@(posedge mclk);
	endtask
	function automatic logic [7:0] expc(input logic byp, input logic [5:0] c);
		return {2'b00, byp ? c : (mcc < c ? mcc : c)};
	endfunction
	task automatic end_sim;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Hang guard; the planned run is about 50k cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 80000) begin
			errors++;
			end_sim();
		end
	end

	initial begin
		{rst, reg_wr, reg_rd, gauge, vph, th, flt} = 9'h100;
		{reg_addr, reg_wdata, mcc} = '0;
		{errors, checked, cyc} = '0;
		void'($urandom(32'hb737));
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++)
			rchk("reset", 8'(8'h80 + i), i == 1 ? 8'hff : 8'h00);
		a = 8'($urandom);
		wr(ADDR_EVENT_MASK, a);
		rchk("mask", ADDR_EVENT_MASK, a);
		wr(ADDR_ONE_CFG, 8'hc0);
		rchk("cfg one", ADDR_ONE_CFG, 8'h80);
		wr(ADDR_TWO_CFG, 8'h7f);
		rchk("cfg two", ADDR_TWO_CFG, 8'h3f);
		wr(ADDR_ONE_READBACK, 8'h3f);
		rchk("readback ro", ADDR_ONE_READBACK, 8'h00);
		wr(ADDR_ONE_CFG, 8'h80);
		wr(ADDR_TWO_CFG, 8'h80);
		// Each event alone unmasked, then all masked
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_EVENT_MASK, ~(8'h01 << i));
			fire(i);
			chk("irq", {7'h00, irq}, 8'h01);
			rchk("flags", ADDR_EVENT_FLAGS, 8'h01 << i);
			chk("irq clear", {7'h00, irq}, 8'h00);
			wr(ADDR_EVENT_MASK, 8'hff);
			fire(i);
			chk("irq masked", {7'h00, irq}, 8'h00);
			rchk("flags masked", ADDR_EVENT_FLAGS, 8'h01 << i);
		end
		@(posedge mclk);
		gauge <= 1'b1;
		wr(ADDR_EVENT_MASK, 8'h00);
		fire(2);
		rchk("cv blocked", ADDR_EVENT_FLAGS, 8'h00);
		@(posedge mclk);
		gauge <= 1'b0;
		// Codes sum to ten, master code random from 3 to 7; bypass alternates per follower
		for (int r = 0; r < 3; r++) begin
			s1 = n1;
			mcc <= 6'(3 + $urandom % 5);
			c1 = 6'(3 + $urandom % 5);
			c2 = 6'(10) - c1;
			wr(ADDR_ONE_CFG, {r[0], 1'b0, c1});
			wr(ADDR_TWO_CFG, {~r[0], 1'b0, c2});
			wait_b(s1 + 1, n2 + 1);
			chk("code one", {2'b00, code1}, expc(r[0], c1));
			chk("code two", {2'b00, code2}, expc(~r[0], c2));
			rchk("rb one", ADDR_ONE_READBACK, expc(r[0], c1));
			rchk("rb two", ADDR_TWO_READBACK, expc(~r[0], c2));
			wr(ADDR_ONE_CFG, 8'h80);
			wr(ADDR_TWO_CFG, 8'h80);
			// Longer link may still owe its gap plus a zero-code gap
			repeat (2 * int'(BURST_GAP_CYC) + 10) @(posedge mclk);
		end
		// Codes changed mid-burst: only the latest follows
		s1 = n1;
		wr(ADDR_ONE_CFG, 8'h84);
		repeat (20) @(posedge mclk);
		wr(ADDR_ONE_CFG, 8'h86);
		wr(ADDR_ONE_CFG, 8'h83);
		wait_b(s1 + 1, 0);
		chk("burst first", {2'b00, code1}, 8'h04);
		wait_b(s1 + 2, 0);
		chk("burst latest", {2'b00, code1}, 8'h03);
		end_sim();
	end
endmodule
